// [pkg/rtc_consts.svh]
// Constants for the rotate-through-carry unit
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

`define RTC_OP_ROT_RIGHT  6'h0c
`define RTC_OP_ROT_LEFT   6'h0d
`define RTC_DEST_ACCUM    1'h0
`define RTC_DEST_FILE     1'h1
`define RTC_FILE_DEPTH    32
`define RTC_BYTE_MSB      7
`define RTC_BYTE_LSB      0
`define RTC_RST_BYTE      8'h00
`define RTC_RST_BIT       1'h0
`define RTC_LOAD_FILE     2'h0
`define RTC_LOAD_ACCUM    2'h1
`define RTC_LOAD_STATUS   2'h2
`define RTC_ST_CARRY      0
`define RTC_ST_DIGIT      1
`define RTC_ST_ZERO       2
`define RTC_EX_SRC        8'he6
`define RTC_EX_RES        8'hcc

`endif

// [pkg/rtc_pkg.sv]
// Types shared by the rotate-through-carry unit
package rtc_pkg;

    typedef enum logic [2:0] {
        OP_NONE                    = 3'b001,
        rotate_right_through_carry = 3'b010,
        rotate_left_through_carry  = 3'b100
    } op_t;

    typedef struct packed {
        logic [5:0] opcode;
        logic       dest;
        logic [4:0] index;
    } instr_t;

    typedef struct packed {
        logic [1:0] target;
        logic [4:0] index;
        logic [7:0] data;
    } load_t;

    typedef struct packed {
        logic       carry;
        logic [7:0] value;
    } rot_t;

endpackage

// [verilog/rotate_core.sv]
// Nine-bit ring rotate of a byte and the carry flag
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"

module rotate_core (
    input  wire logic [7:0]   i_value,
    input  wire logic         i_carry,
    input  wire rtc_pkg::op_t i_op,
    output var rtc_pkg::rot_t o_result
);
    always_comb begin
        o_result = {i_carry, i_value};
        unique case (i_op)
            rtc_pkg::rotate_right_through_carry: begin // [RULE_01]
                // Carry into the top, low bit out to carry
                o_result = {i_value[`RTC_BYTE_LSB], i_carry,
                            i_value[`RTC_BYTE_MSB:`RTC_BYTE_LSB+1]};
            end
            rtc_pkg::rotate_left_through_carry: begin
                o_result = {i_value[`RTC_BYTE_MSB],
                            i_value[`RTC_BYTE_MSB-1:`RTC_BYTE_LSB],
                            i_carry}; // [RULE_07]
            end
            rtc_pkg::OP_NONE: begin
                o_result = {i_carry, i_value};
            end
            default: begin
                o_result = {i_carry, i_value};
            end
        endcase
    end
endmodule
`default_nettype wire

// [verilog/rotate_through_carry_unit.sv]
// Rotate-through-carry execution datapath with file registers
//
// Contract
// RULE_01: Rotate right moves carry into bit 7 and bit 0 into carry.
// RULE_02: Destination 0 writes the accumulator and leaves the file alone.
// RULE_03: Destination 1 writes back into the source file register.
// RULE_04: Rotate right decodes from 0011 00df ffff, d bit 5, f bits 4..0.
// RULE_05: A rotate is one word and completes in one cycle.
// RULE_06: Rotate left of 1110 0110, carry 0, gives 1100 1100, carry 1.
// RULE_07: Rotate left decodes from 0011 01df ffff, left through carry.
// RULE_08: Rotates change only carry, never zero or digit carry.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"

module rotate_through_carry_unit #(
    parameter int DEPTH = `RTC_FILE_DEPTH
) (
    input  wire logic             i_clock,
    input  wire logic             i_nrst,
    input  wire logic             i_enable,
    input  wire logic             i_instr_valid,
    input  wire rtc_pkg::instr_t  i_instr,
    input  wire logic             i_load_valid,
    input  wire rtc_pkg::load_t   i_load,
    input  wire logic [4:0]       i_read_index,
    output logic [7:0]            o_accum,
    output logic                  o_carry,
    output logic                  o_digit_carry,
    output logic                  o_zero,
    output logic                  o_done,
    output logic [7:0]            o_read_data
);
    logic             rst_meta_n_r;
    logic             rst_n_r;
    logic [7:0]       file_r [DEPTH];
    logic [7:0]       acc_r;
    logic             carry_r;
    logic             digit_r;
    logic             zero_r;
    logic             done_r;
    logic [7:0]       read_r;
    rtc_pkg::op_t     op;
    rtc_pkg::rot_t    rot;
    logic [7:0]       src;
    logic             take;
    logic             load_ok;

    function automatic rtc_pkg::op_t decode_op(input rtc_pkg::instr_t ins);
        if (ins.opcode == `RTC_OP_ROT_RIGHT) begin
            return rtc_pkg::rotate_right_through_carry; // [RULE_04]
        end
        if (ins.opcode == `RTC_OP_ROT_LEFT) begin
            return rtc_pkg::rotate_left_through_carry; // [RULE_07]
        end
        return rtc_pkg::OP_NONE;
    endfunction

    // Reset release through two flops; enable gates them like all state
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_n_r <= 1'b0;
            rst_n_r      <= 1'b0;
        end else if (i_enable) begin
            rst_meta_n_r <= 1'b1;
            rst_n_r      <= rst_meta_n_r;
        end
    end

    assign op      = decode_op(i_instr);
    assign take    = i_enable && i_instr_valid &&
                     (op != rtc_pkg::OP_NONE); // [RULE_05]
    // Preload loses to a rotate so flags and targets stay coherent
    assign load_ok = i_enable && i_load_valid && !take;
    assign src     = file_r[i_instr.index];

    rotate_core u_core (
        .i_value  (src),
        .i_carry  (carry_r),
        .i_op     (op),
        .o_result (rot)
    );

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_file
            always_ff @(posedge i_clock or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    file_r[g] <= `RTC_RST_BYTE;
                end else if (take && i_instr.dest == `RTC_DEST_FILE &&
                             i_instr.index == 5'(g)) begin
                    file_r[g] <= rot.value; // [RULE_03]
                end else if (load_ok && i_load.target == `RTC_LOAD_FILE &&
                             i_load.index == 5'(g)) begin
                    file_r[g] <= i_load.data;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            acc_r <= `RTC_RST_BYTE;
        end else if (take && i_instr.dest == `RTC_DEST_ACCUM) begin
            acc_r <= rot.value; // [RULE_02]
        end else if (load_ok && i_load.target == `RTC_LOAD_ACCUM) begin
            acc_r <= i_load.data;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            carry_r <= `RTC_RST_BIT;
        end else if (take) begin
            carry_r <= rot.carry; // [RULE_01] [RULE_07]
        end else if (load_ok && i_load.target == `RTC_LOAD_STATUS) begin
            carry_r <= i_load.data[`RTC_ST_CARRY];
        end
    end

    // Zero and digit-carry only move on a status preload
    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            digit_r <= `RTC_RST_BIT;
            zero_r  <= `RTC_RST_BIT;
        end else if (load_ok && i_load.target == `RTC_LOAD_STATUS) begin
            digit_r <= i_load.data[`RTC_ST_DIGIT]; // [RULE_08]
            zero_r  <= i_load.data[`RTC_ST_ZERO]; // [RULE_08]
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            done_r <= 1'b0;
        end else if (i_enable) begin
            done_r <= take; // [RULE_05]
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_r) begin
        if (!rst_n_r) begin
            read_r <= `RTC_RST_BYTE;
        end else if (i_enable) begin
            read_r <= file_r[i_read_index];
        end
    end

    assign o_accum       = acc_r;
    assign o_carry       = carry_r;
    assign o_digit_carry = digit_r;
    assign o_zero        = zero_r;
    assign o_done        = done_r;
    assign o_read_data   = read_r;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rst_n_r);

    sequence s_take_right;
        take && op == rtc_pkg::rotate_right_through_carry;
    endsequence

    sequence s_take_left;
        take && op == rtc_pkg::rotate_left_through_carry;
    endsequence

    sequence s_to_accum;
        i_instr.dest == `RTC_DEST_ACCUM;
    endsequence

    property p_right_value;
        s_take_right ##0 s_to_accum |=>
            acc_r == {$past(carry_r), $past(src[7:1])} &&
            carry_r == $past(src[0]);
    endproperty
    a_right_value: assert property (p_right_value) // [RULE_01]
        else $error("rotate right result or carry wrong");

    property p_accum_keeps_file;
        take ##0 s_to_accum |=>
            file_r[$past(i_instr.index)] == $past(src);
    endproperty
    a_accum_keeps_file: assert property (p_accum_keeps_file) // [RULE_02]
        else $error("file register changed on accumulator destination");

    property p_file_dest;
        take && i_instr.dest == `RTC_DEST_FILE |=>
            file_r[$past(i_instr.index)] == $past(rot.value) &&
            acc_r == $past(acc_r);
    endproperty
    a_file_dest: assert property (p_file_dest) // [RULE_03]
        else $error("file destination write wrong");

    property p_decode_right;
        i_enable && i_instr_valid && i_instr.opcode == `RTC_OP_ROT_RIGHT
            |=> done_r;
    endproperty
    a_decode_right: assert property (p_decode_right) // [RULE_04]
        else $error("rotate right pattern not executed");

    property p_ignore_other;
        i_enable && !take && !load_ok |=>
            acc_r == $past(acc_r) && carry_r == $past(carry_r) && !done_r;
    endproperty
    a_ignore_other: assert property (p_ignore_other) // [RULE_04]
        else $error("unrecognised word changed state");

    property p_single_cycle;
        take ##1 (i_enable && !take) |=> !done_r;
    endproperty
    a_single_cycle: assert property (p_single_cycle) // [RULE_05]
        else $error("done pulse longer than one cycle");

    property p_example;
        s_take_left ##0 s_to_accum ##0
            (src == `RTC_EX_SRC && !carry_r) |=>
            acc_r == `RTC_EX_RES && carry_r &&
            file_r[$past(i_instr.index)] == `RTC_EX_SRC;
    endproperty
    a_example: assert property (p_example) // [RULE_06]
        else $error("rotate left example result wrong");

    property p_left_value;
        s_take_left ##0 i_instr.dest == `RTC_DEST_FILE |=>
            file_r[$past(i_instr.index)] ==
                {$past(src[6:0]), $past(carry_r)} &&
            carry_r == $past(src[7]);
    endproperty
    a_left_value: assert property (p_left_value) // [RULE_07]
        else $error("rotate left result or carry wrong");

    property p_flags_kept;
        take |=> $stable(zero_r) && $stable(digit_r);
    endproperty
    a_flags_kept: assert property (p_flags_kept) // [RULE_08]
        else $error("zero or digit carry changed by rotate");

endmodule
`default_nettype wire

// [dv/tb_rotate_through_carry_unit.sv]
// Self-checking random bench for the rotate-through-carry unit
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"

module tb_rotate_through_carry_unit;
    logic            i_clock;
    logic            i_nrst;
    logic            i_enable;
    logic            i_instr_valid;
    rtc_pkg::instr_t i_instr;
    logic            i_load_valid;
    rtc_pkg::load_t  i_load;
    logic [4:0]      i_read_index;
    logic [7:0]      o_accum;
    logic            o_carry;
    logic            o_digit_carry;
    logic            o_zero;
    logic            o_done;
    logic [7:0]      o_read_data;
    logic [7:0]      m_file [32];
    logic [7:0]      m_acc;
    logic [7:0]      m_rd;
    logic [2:0]      m_st;
    logic            m_done;
    logic [1:0]      m_sync;
    int              fail_count;
    int              num_checks;

    rotate_through_carry_unit i_dut (
        .i_clock       (i_clock),
        .i_nrst        (i_nrst),
        .i_enable      (i_enable),
        .i_instr_valid (i_instr_valid),
        .i_instr       (i_instr),
        .i_load_valid  (i_load_valid),
        .i_load        (i_load),
        .i_read_index  (i_read_index),
        .o_accum       (o_accum),
        .o_carry       (o_carry),
        .o_digit_carry (o_digit_carry),
        .o_zero        (o_zero),
        .o_done        (o_done),
        .o_read_data   (o_read_data)
    );

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // Nine-bit ring: {new carry, new byte}
    function automatic logic [8:0] ring(input logic left, input logic [7:0] v,
                                        input logic c);
        return left ? {v, c} : {v[0], c, v[7:1]};
    endfunction

    // Everything the unit clears while its internal reset is low
    task automatic model_reset;
        foreach (m_file[k]) m_file[k] = 8'h00;
        m_acc = 8'h00;
        m_rd = 8'h00;
        m_st = 3'h0;
        m_done = 1'b0;
    endtask

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One clock: drive at falling edge, predict, compare after rising edge
    task automatic cycle(input logic en, input logic iv,
                         input rtc_pkg::instr_t ins, input logic lv,
                         input rtc_pkg::load_t ld, input logic [4:0] ri);
        logic       tk;
        logic [8:0] r;
        @(negedge i_clock);
        i_enable = en;
        i_instr_valid = iv;
        i_instr = ins;
        i_load_valid = lv;
        i_load = ld;
        i_read_index = ri;
        tk = iv && (ins.opcode == `RTC_OP_ROT_RIGHT ||
                    ins.opcode == `RTC_OP_ROT_LEFT);
        if (!i_nrst) begin
            model_reset();
            m_sync = 2'b00;
        end else if (en && !m_sync[1]) begin
            // Internal reset copy is still low at this edge
            model_reset();
            m_sync = {m_sync[0], 1'b1};
        end else if (en) begin
            m_rd = m_file[ri];
            m_done = tk;
            if (tk) begin
                r = ring(ins.opcode[0], m_file[ins.index], m_st[0]);
                m_st[0] = r[8];
                if (ins.dest) m_file[ins.index] = r[7:0];
                else m_acc = r[7:0];
            end else if (lv) begin
                case (ld.target)
                    2'h0: m_file[ld.index] = ld.data;
                    2'h1: m_acc = ld.data;
                    2'h2: m_st = ld.data[2:0];
                    default: ;
                endcase
            end
        end
        @(posedge i_clock);
        #1;
        check("accum", o_accum, m_acc);
        check("carry", {7'h00, o_carry}, {7'h00, m_st[0]});
        check("zdc", 8'({o_zero, o_digit_carry}), 8'(m_st[2:1]));
        check("done", {7'h00, o_done}, {7'h00, m_done});
        check("read_data", o_read_data, m_rd);
    endtask

    task automatic rot(input logic [5:0] op, input logic d, input logic [4:0] f);
        cycle(1'b1, 1'b1, {op, d, f}, 1'b0, 15'h0000, f);
    endtask

    task automatic pre(input logic [1:0] t, input logic [4:0] f, input logic [7:0] v);
        cycle(1'b1, 1'b0, 12'h000, 1'b1, {t, f, v}, f);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        rtc_pkg::instr_t ins;
        rtc_pkg::load_t  ld;
        logic            lv;
        fail_count = 0;
        num_checks = 0;
        i_nrst = 1'b0;
        i_enable = 1'b1;
        i_instr_valid = 1'b0;
        i_instr = 12'h000;
        i_load_valid = 1'b0;
        i_load = 15'h0000;
        i_read_index = 5'h00;
        model_reset();
        m_sync = 2'b00;
        void'($urandom(32'hbcbb937c));
        // Requests even during reset must not disturb the zeroed state
        repeat (10) cycle(1'b1, 1'b1, 12'h325, 1'b1, 15'h7fff, 5'h05);
        i_nrst = 1'b1;
        repeat (2) rot(`RTC_OP_ROT_RIGHT, 1'b1, 5'h05);
        $display("test reset done");
        pre(2'h2, 5'h00, 8'h06);
        pre(2'h0, 5'h03, `RTC_EX_SRC);
        rot(`RTC_OP_ROT_LEFT, `RTC_DEST_ACCUM, 5'h03);
        check("example_accum", o_accum, `RTC_EX_RES);
        check("example_carry", {7'h00, o_carry}, 8'h01);
        rot(6'h0e, 1'b1, 5'h03);
        check("example_file", o_read_data, `RTC_EX_SRC);
        $display("test example done");
        for (int k = 0; k < 32; k++) pre(2'h0, k[4:0], 8'($urandom));
        for (int k = 0; k < 128; k++)
            rot({5'h06, k[0]}, k[1], k[6:2]);
        $display("test back_to_back done");
        // A rotate wins over a preload in the same cycle
        cycle(1'b1, 1'b1, 12'h345, 1'b1, {2'h1, 5'h00, 8'h5a}, 5'h05);
        for (int k = 0; k < 40; k++) begin
            ins = 12'($urandom);
            if (ins.opcode[5:1] == 5'h06) ins.opcode = 6'h0e;
            lv = 1'($urandom);
            ld = 15'($urandom);
            cycle(1'b1, 1'b1, ins, lv, ld, 5'($urandom));
        end
        $display("test refused done");
        for (int k = 0; k < 3000; k++) begin
            ins = 12'($urandom);
            if ($urandom_range(3) != 0) ins.opcode = {5'h06, 1'($urandom)};
            cycle($urandom_range(9) != 0, 1'($urandom), ins, 1'($urandom),
                  15'($urandom), 5'($urandom));
        end
        $display("test random done");
        // Mid-run reset clears state; rotates refused until release
        i_nrst = 1'b0;
        repeat (3) cycle(1'b1, 1'b1, 12'h345, 1'b1, 15'h7fff, 5'h05);
        i_nrst = 1'b1;
        repeat (3) rot(`RTC_OP_ROT_LEFT, `RTC_DEST_FILE, 5'h05);
        $display("test mid_reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
